// file: hdl/csw_defs.svh
// Constants for the compact word-store and register exclusive-OR execute block
// What this block does
// - Every word store raises an address error when either of the two low address bits is set, before any write.
// - The short base-register store carries a 5-bit unsigned offset that is scaled by four.
// - The short base-register store appends two zero bits to the offset, zero-extends it and adds the base register.
// - The extended base-register store (prefix 11110, major 11011) builds a 16-bit offset from three fields, sign-extends it and adds the base.
// - The short stack store scales an 8-bit offset by four, zero-extends it, adds register 29 and stores the chosen source.
// - The extended stack store (prefix 11110, major 11010, bits 7..5 zero) sign-extends its 16-bit offset and adds the stack pointer.
// - The short return-address store decodes major 01100, function 010 in bits 10..8, an 8-bit offset in bits 7..0, and stores register 31.
// - The extended return-address store adds the prefix to major 01100 function 010 with bits 7..5 zero, sign-extends the offset onto the stack pointer and stores register 31.
// - Each store translates its address as a data store, gets a physical address and cache attribute, and flips physical bit 2 in reversed byte order.
// - The byte select is virtual bits 2..0 with bit 2 flipped on a high-first core; the source shifts left by eight times it and a word store issues.
// - Base and stack stores can report refill, invalid, modified, bus error and address error.
// - Return-address stores report refill, invalid, modified and address error, never a bus error.
// - The register exclusive-OR decodes group 11101 function 01110 and writes the XOR of both registers into the first one.
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH
`define CSW_XLEN 64
`define CSW_PAW 32
`define CSW_OP_EXTEND 5'h1e
`define CSW_OP_SW 5'h1b
`define CSW_OP_STACK_STORE_OP 5'h1a
`define CSW_OP_I8 5'h0c
`define CSW_OP_RR 5'h1d
`define CSW_FN_RETURN_ADDR_STACK_STORE_FN 3'h2
`define CSW_FN_XOR 5'h0e
`define CSW_GPR_SP 5'h1d
`define CSW_GPR_RA 5'h1f
`define CSW_XLAT_LOW 5'h10
`define CSW_LANE_FLIP 3'h4
`define CSW_ALIGNED 2'h0
`define CSW_ZERO3 3'h0
`endif

// file: hdl/csw_pkg.sv
// Types shared by the compact word-store execute block
`default_nettype none
package csw_pkg;
  typedef enum logic [2:0] {
    CSW_EXC_NONE,
    CSW_EXC_ADDR,
    CSW_EXC_TLB_REFILL,
    CSW_EXC_TLB_INVALID,
    CSW_EXC_TLB_MODIFIED,
    CSW_EXC_BUS
  } csw_exc_t;
  typedef enum logic [1:0] {
    CSW_KIND_NONE,
    CSW_KIND_STORE,
    CSW_KIND_XOR
  } csw_kind_t;
  typedef enum logic [2:0] {
    CSW_ST_IDLE,
    CSW_ST_READ,
    CSW_ST_ADDR,
    CSW_ST_XLAT,
    CSW_ST_STORE
  } csw_state_t;
endpackage : csw_pkg
`default_nettype wire

// file: hdl/csw_dec.sv
// Instruction decoder for the word-store forms and register exclusive-OR
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.svh"
module csw_dec
  import csw_pkg::*;
(
  input wire logic [31:0] i_instr,
  input wire logic i_ext,
  output csw_kind_t o_kind,
  output logic [4:0] o_base,
  output logic [4:0] o_src,
  output logic [63:0] o_offset,
  output logic o_ra_form
);
  // Three-bit register field to full register number
  function automatic logic [4:0] csw_xlat(input logic [2:0] r);
    csw_xlat = (r[2:1] == 2'h0) ? (`CSW_XLAT_LOW | {4'h0, r[0]}) : {2'h0, r};
  endfunction : csw_xlat

  logic [4:0] op;
  logic [15:0] off16;
  logic pre_ok;
  assign op = i_instr[15:11];
  assign off16 = {i_instr[20:16], i_instr[26:21], i_instr[4:0]};
  assign pre_ok = i_instr[31:27] == `CSW_OP_EXTEND;

  // Form selection; an unknown or ill-formed pattern decodes to none
  always_comb begin
    o_kind = CSW_KIND_NONE;
    o_base = csw_xlat(i_instr[10:8]);
    o_src = csw_xlat(i_instr[7:5]);
    o_offset = 64'h0000_0000_0000_0000;
    o_ra_form = 1'b0;
    if (i_ext && !pre_ok) begin
      o_kind = CSW_KIND_NONE;
    end else if (op == `CSW_OP_SW) begin
      o_kind = CSW_KIND_STORE;
      o_offset = i_ext ? {{48{off16[15]}}, off16}
                       : {57'h0, i_instr[4:0], 2'h0};
    end else if (op == `CSW_OP_STACK_STORE_OP && (!i_ext || i_instr[7:5] == `CSW_ZERO3)) begin
      o_kind = CSW_KIND_STORE;
      o_base = `CSW_GPR_SP;
      o_src = csw_xlat(i_instr[10:8]);
      o_offset = i_ext ? {{48{off16[15]}}, off16} : {54'h0, i_instr[7:0], 2'h0};
    end else if (op == `CSW_OP_I8 && i_instr[10:8] == `CSW_FN_RETURN_ADDR_STACK_STORE_FN
                 && (!i_ext || i_instr[7:5] == `CSW_ZERO3)) begin
      o_kind = CSW_KIND_STORE;
      o_base = `CSW_GPR_SP;
      o_src = `CSW_GPR_RA;
      o_ra_form = 1'b1;
      o_offset = i_ext ? {{48{off16[15]}}, off16} : {54'h0, i_instr[7:0], 2'h0};
    end else if (!i_ext && op == `CSW_OP_RR && i_instr[4:0] == `CSW_FN_XOR) begin
      o_kind = CSW_KIND_XOR;
    end
  end
endmodule : csw_dec
`default_nettype wire

// file: hdl/csw_lane.sv
// Effective address, alignment check and store lane placement
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.svh"
module csw_lane (
  input wire logic [63:0] i_base,
  input wire logic [63:0] i_offset,
  input wire logic [63:0] i_src,
  input wire logic i_high_first,
  output logic [63:0] o_vaddr,
  output logic o_misaligned,
  output logic [63:0] o_data
);
  logic [2:0] bytesel;
  // Wraps modulo two to the sixty-four, as address arithmetic should
  assign o_vaddr = i_base + i_offset;
  assign o_misaligned = o_vaddr[1:0] != `CSW_ALIGNED;
  // Lane select and shift into the doubleword
  assign bytesel = o_vaddr[2:0] ^ (i_high_first ? `CSW_LANE_FLIP : 3'h0);
  assign o_data = i_src << {bytesel, 3'h0};
endmodule : csw_lane
`default_nettype wire

// file: hdl/csw_exec.sv
// Execute sequencer for compact word stores and register exclusive-OR
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.svh"
module csw_exec
  import csw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic i_instr_ext,
  input wire logic i_reversed_byte_order_flag,
  input wire logic i_core_high_first_order_flag,
  input wire logic [63:0] i_rf_rdata_a,
  input wire logic [63:0] i_rf_rdata_b,
  input wire logic i_xlat_done,
  input wire logic [31:0] i_xlat_paddr,
  input wire logic [2:0] i_xlat_cache_attribute,
  input wire logic i_xlat_refill,
  input wire logic i_xlat_invalid,
  input wire logic i_xlat_modified,
  input wire logic i_mem_ack,
  input wire logic i_mem_bus_err,
  output logic o_ready,
  output logic [4:0] o_rf_raddr_a,
  output logic [4:0] o_rf_raddr_b,
  output logic o_rf_we,
  output logic [4:0] o_rf_waddr,
  output logic [63:0] o_rf_wdata,
  output logic o_xlat_req,
  output logic [63:0] o_xlat_vaddr,
  output logic o_mem_req,
  output logic [31:0] o_mem_paddr,
  output logic [63:0] o_mem_vaddr,
  output logic [63:0] o_mem_data,
  output logic [2:0] o_mem_cache_attribute,
  output logic o_exc_valid,
  output csw_exc_t o_exc_code,
  output logic o_done
);
  csw_state_t state_reg;
  csw_kind_t dec_kind;
  logic [4:0] dec_base;
  logic [4:0] dec_src;
  logic [63:0] dec_offset;
  logic dec_ra_form;

  csw_kind_t kind_reg;
  logic ra_form_reg;
  logic [63:0] offset_reg;
  logic [63:0] opa_reg;
  logic [63:0] opb_reg;
  logic [63:0] store_data_reg;

  logic [63:0] lane_vaddr;
  logic lane_misaligned;
  logic [63:0] lane_data;

  logic ready_reg;
  logic [4:0] raddr_a_reg;
  logic [4:0] raddr_b_reg;
  logic rf_we_reg;
  logic [4:0] rf_waddr_reg;
  logic [63:0] rf_wdata_reg;
  logic xlat_req_reg;
  logic [63:0] xlat_vaddr_reg;
  logic mem_req_reg;
  logic [31:0] mem_paddr_reg;
  logic [63:0] mem_data_reg;
  logic [2:0] mem_cca_reg;
  logic exc_valid_reg;
  csw_exc_t exc_code_reg;
  logic done_reg;

  logic accept;
  logic xlat_fault;
  csw_exc_t xlat_code;
  logic bus_fault;

  // Handshake and fault terms
  assign accept = (state_reg == CSW_ST_IDLE) && i_instr_valid;
  assign xlat_fault = i_xlat_refill || i_xlat_invalid || i_xlat_modified;
  // Return-address stores never surface a bus error
  assign bus_fault = i_mem_bus_err && !ra_form_reg;

  // Translation fault priority: refill, then invalid, then modified
  always_comb begin
    xlat_code = CSW_EXC_NONE;
    if (i_xlat_refill) begin
      xlat_code = CSW_EXC_TLB_REFILL;
    end else if (i_xlat_invalid) begin
      xlat_code = CSW_EXC_TLB_INVALID;
    end else if (i_xlat_modified) begin
      xlat_code = CSW_EXC_TLB_MODIFIED;
    end
  end

  // Decoder looks at the raw instruction in the accept cycle
  csw_dec u_dec (
    .i_instr(i_instr),
    .i_ext(i_instr_ext),
    .o_kind(dec_kind),
    .o_base(dec_base),
    .o_src(dec_src),
    .o_offset(dec_offset),
    .o_ra_form(dec_ra_form)
  );

  // Address and lane unit works from the captured operands
  csw_lane u_lane (
    .i_base(opa_reg),
    .i_offset(offset_reg),
    .i_src(opb_reg),
    .i_high_first(i_core_high_first_order_flag),
    .o_vaddr(lane_vaddr),
    .o_misaligned(lane_misaligned),
    .o_data(lane_data)
  );

  // Sequencer state
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= CSW_ST_IDLE;
    end else begin
      case (state_reg)
        CSW_ST_IDLE: begin
          if (i_instr_valid) begin
            state_reg <= CSW_ST_READ;
          end
        end
        CSW_ST_READ: begin
          state_reg <= CSW_ST_ADDR;
        end
        CSW_ST_ADDR: begin
          // Misaligned stores stop here, before translation
          if (kind_reg == CSW_KIND_STORE && !lane_misaligned) begin
            state_reg <= CSW_ST_XLAT;
          end else begin
            state_reg <= CSW_ST_IDLE;
          end
        end
        CSW_ST_XLAT: begin
          if (i_xlat_done) begin
            state_reg <= xlat_fault ? CSW_ST_IDLE : CSW_ST_STORE;
          end
        end
        CSW_ST_STORE: begin
          if (i_mem_ack) begin
            state_reg <= CSW_ST_IDLE;
          end
        end
        default: begin
          state_reg <= CSW_ST_IDLE;
        end
      endcase
    end
  end

  // Captured decode results
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      kind_reg <= CSW_KIND_NONE;
      ra_form_reg <= 1'b0;
      offset_reg <= 64'h0000_0000_0000_0000;
    end else if (accept) begin
      kind_reg <= dec_kind;
      ra_form_reg <= dec_ra_form;
      offset_reg <= dec_offset;
    end
  end

  // Register file read ports; data is expected in the read cycle
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      raddr_a_reg <= 5'h00;
      raddr_b_reg <= 5'h00;
      opa_reg <= 64'h0000_0000_0000_0000;
      opb_reg <= 64'h0000_0000_0000_0000;
    end else if (accept) begin
      raddr_a_reg <= dec_base;
      raddr_b_reg <= dec_src;
    end else if (state_reg == CSW_ST_READ) begin
      opa_reg <= i_rf_rdata_a;
      opb_reg <= i_rf_rdata_b;
    end
  end

  // Ready drops at accept and returns the cycle after the done or exception pulse
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ready_reg <= 1'b1;
    end else if (accept) begin
      ready_reg <= 1'b0;
    end else if (done_reg || exc_valid_reg) begin
      ready_reg <= 1'b1;
    end
  end

  // Exclusive-OR write-back; never restricted, never faults
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rf_we_reg <= 1'b0;
      rf_waddr_reg <= 5'h00;
      rf_wdata_reg <= 64'h0000_0000_0000_0000;
    end else begin
      rf_we_reg <= (state_reg == CSW_ST_ADDR) && (kind_reg == CSW_KIND_XOR);
      if (state_reg == CSW_ST_ADDR && kind_reg == CSW_KIND_XOR) begin
        rf_waddr_reg <= raddr_a_reg;
        rf_wdata_reg <= opa_reg ^ opb_reg;
      end
    end
  end

  // Data-store translation request, held until the answer
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      xlat_req_reg <= 1'b0;
      xlat_vaddr_reg <= 64'h0000_0000_0000_0000;
      store_data_reg <= 64'h0000_0000_0000_0000;
    end else if (state_reg == CSW_ST_ADDR) begin
      xlat_req_reg <= (kind_reg == CSW_KIND_STORE) && !lane_misaligned;
      xlat_vaddr_reg <= lane_vaddr;
      store_data_reg <= lane_data;
    end else if (state_reg == CSW_ST_XLAT && i_xlat_done) begin
      xlat_req_reg <= 1'b0;
    end
  end

  // Word store to memory; only a clean translation opens it
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mem_req_reg <= 1'b0;
      mem_paddr_reg <= 32'h0000_0000;
      mem_data_reg <= 64'h0000_0000_0000_0000;
      mem_cca_reg <= 3'h0;
    end else if (state_reg == CSW_ST_XLAT && i_xlat_done) begin
      mem_req_reg <= !xlat_fault;
      // Reversed byte order flips physical bit 2 only
      mem_paddr_reg <= {i_xlat_paddr[31:3],
                        i_xlat_paddr[2] ^ i_reversed_byte_order_flag,
                        i_xlat_paddr[1:0]};
      mem_cca_reg <= i_xlat_cache_attribute;
      mem_data_reg <= store_data_reg;
    end else if (state_reg == CSW_ST_STORE && i_mem_ack) begin
      mem_req_reg <= 1'b0;
    end
  end

  // Exception report, one pulse per faulting instruction
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      exc_valid_reg <= 1'b0;
      exc_code_reg <= CSW_EXC_NONE;
    end else begin
      exc_valid_reg <= 1'b0;
      if (state_reg == CSW_ST_ADDR && kind_reg == CSW_KIND_STORE && lane_misaligned) begin
        exc_valid_reg <= 1'b1;
        exc_code_reg <= CSW_EXC_ADDR;
      end else if (state_reg == CSW_ST_XLAT && i_xlat_done && xlat_fault) begin
        exc_valid_reg <= 1'b1;
        exc_code_reg <= xlat_code;
      end else if (state_reg == CSW_ST_STORE && i_mem_ack && bus_fault) begin
        // Bus error arrives with the ack, too late to suppress the write
        exc_valid_reg <= 1'b1;
        exc_code_reg <= CSW_EXC_BUS;
      end
    end
  end

  // Completion pulse for every instruction that ends without a fault
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= ((state_reg == CSW_ST_ADDR) && (kind_reg != CSW_KIND_STORE))
                  || ((state_reg == CSW_ST_STORE) && i_mem_ack && !bus_fault);
    end
  end

  // Ports straight from flops
  assign o_ready = ready_reg;
  assign o_rf_raddr_a = raddr_a_reg;
  assign o_rf_raddr_b = raddr_b_reg;
  assign o_rf_we = rf_we_reg;
  assign o_rf_waddr = rf_waddr_reg;
  assign o_rf_wdata = rf_wdata_reg;
  assign o_xlat_req = xlat_req_reg;
  assign o_xlat_vaddr = xlat_vaddr_reg;
  assign o_mem_req = mem_req_reg;
  assign o_mem_paddr = mem_paddr_reg;
  assign o_mem_vaddr = xlat_vaddr_reg;
  assign o_mem_data = mem_data_reg;
  assign o_mem_cache_attribute = mem_cca_reg;
  assign o_exc_valid = exc_valid_reg;
  assign o_exc_code = exc_code_reg;
  assign o_done = done_reg;
endmodule : csw_exec
`default_nettype wire

// file: tb/csw_xlat_mem_model.sv
// Behavioural translation and store-path partner with adjustable latency and faults
`timescale 1ns/1ns
`default_nettype none
module csw_xlat_mem_model (
  input wire logic i_clk,
  input wire logic i_xlat_req,
  input wire logic i_mem_req,
  input wire logic [3:0] i_wait,
  input wire logic [1:0] i_fault,
  input wire logic i_bus_err,
  input wire logic [31:0] i_paddr,
  output logic o_xlat_done,
  output logic [31:0] o_xlat_paddr,
  output logic [2:0] o_cca,
  output logic o_refill,
  output logic o_invalid,
  output logic o_modified,
  output logic o_mem_ack,
  output logic o_mem_bus_err
);
  logic [3:0] wait_reg = 4'h0;
  // One-cycle answer after i_wait idle cycles; never re-fires on the consuming edge
  always @(posedge i_clk) begin
    o_xlat_done <= 1'b0;
    o_mem_ack <= 1'b0;
    if ((i_xlat_req || i_mem_req) && !o_xlat_done && !o_mem_ack) begin
      if (wait_reg == i_wait) begin
        wait_reg <= 4'h0;
        o_xlat_done <= i_xlat_req;
        o_mem_ack <= i_mem_req && !i_xlat_req;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
  // Result lines carry junk outside an answer, so stale sampling shows up
  assign o_xlat_paddr = o_xlat_done ? i_paddr : ~i_paddr;
  assign o_cca = o_xlat_done ? 3'h5 : 3'h2;
  assign o_refill = o_xlat_done ? (i_fault == 2'h1) : 1'b1;
  assign o_invalid = o_xlat_done ? (i_fault == 2'h2) : 1'b1;
  assign o_modified = o_xlat_done ? (i_fault == 2'h3) : 1'b1;
  assign o_mem_bus_err = o_mem_ack ? i_bus_err : 1'b1;
endmodule : csw_xlat_mem_model
`default_nettype wire

// file: tb/csw_exec_asserts.sv
// Port checker for the compact word-store execute block
`timescale 1ns/1ns
`default_nettype none
`include "csw_defs.svh"
module csw_exec_asserts
  import csw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_reversed_byte_order_flag,
  input wire logic i_core_high_first_order_flag,
  input wire logic [63:0] i_rf_rdata_a,
  input wire logic [63:0] i_rf_rdata_b,
  input wire logic i_xlat_done,
  input wire logic [31:0] i_xlat_paddr,
  input wire logic i_xlat_refill,
  input wire logic i_mem_ack,
  input wire logic i_mem_bus_err,
  input wire logic [4:0] o_rf_raddr_a,
  input wire logic [4:0] o_rf_raddr_b,
  input wire logic o_rf_we,
  input wire logic [4:0] o_rf_waddr,
  input wire logic [63:0] o_rf_wdata,
  input wire logic o_xlat_req,
  input wire logic [63:0] o_xlat_vaddr,
  input wire logic o_mem_req,
  input wire logic [31:0] o_mem_paddr,
  input wire logic [63:0] o_mem_vaddr,
  input wire logic [63:0] o_mem_data,
  input wire logic o_exc_valid,
  input wire csw_exc_t o_exc_code,
  input wire logic o_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Byte lane of the store; only the return-address form reads register 31
  logic [2:0] lane_sel;
  logic ra_form;
  assign lane_sel = o_mem_vaddr[2:0] ^ {i_core_high_first_order_flag, 2'h0};
  assign ra_form = (o_rf_raddr_b == `CSW_GPR_RA);
  a_xlat_aligned: assert property (o_xlat_req |-> o_xlat_vaddr[1:0] == 2'h0)
    else $error("misaligned address sent to translation");
  a_fault_no_write: assert property ((o_xlat_req && i_xlat_done && i_xlat_refill) |=>
    o_exc_valid && o_exc_code == CSW_EXC_TLB_REFILL && !o_mem_req)
    else $error("translation fault did not stop the store");
  a_paddr_flip: assert property ($rose(o_mem_req) |-> o_mem_paddr ==
    ($past(i_xlat_paddr) ^ {29'h0, $past(i_reversed_byte_order_flag), 2'h0}))
    else $error("physical address lane wrong");
  a_lane_data: assert property (o_mem_req |->
    o_mem_data == (i_rf_rdata_b << {lane_sel, 3'h0}))
    else $error("store data lane wrong");
  a_xor_wb: assert property (o_rf_we |-> o_done && o_rf_waddr == o_rf_raddr_a &&
    o_rf_wdata == (i_rf_rdata_a ^ i_rf_rdata_b))
    else $error("exclusive-or write-back wrong");
  a_bus_err_code: assert property ((o_mem_req && i_mem_ack && i_mem_bus_err && !ra_form)
    |=> o_exc_valid && o_exc_code == CSW_EXC_BUS && !o_done)
    else $error("bus error not reported");
  a_ra_no_bus: assert property ((o_mem_req && i_mem_ack && i_mem_bus_err && ra_form)
    |=> o_done && !o_exc_valid)
    else $error("return-address store reported a bus error");
  a_xlat_hold: assert property ((o_xlat_req && !i_xlat_done) |=>
    o_xlat_req && $stable(o_xlat_vaddr))
    else $error("translation request dropped early");
  c_xor: cover property (o_rf_we);
  c_store: cover property (o_mem_req && i_mem_ack);
  c_addr_err: cover property (o_exc_valid && o_exc_code == CSW_EXC_ADDR);
endmodule : csw_exec_asserts
bind csw_exec csw_exec_asserts u_chk (.i_clk, .i_rstn, .i_reversed_byte_order_flag,
  .i_core_high_first_order_flag, .i_rf_rdata_a, .i_rf_rdata_b, .i_xlat_done, .i_xlat_paddr,
  .i_xlat_refill, .i_mem_ack, .i_mem_bus_err, .o_rf_raddr_a, .o_rf_raddr_b, .o_rf_we,
  .o_rf_waddr, .o_rf_wdata, .o_xlat_req, .o_xlat_vaddr, .o_mem_req, .o_mem_paddr,
  .o_mem_vaddr, .o_mem_data, .o_exc_valid, .o_exc_code, .o_done);
`default_nettype wire

// file: tb/test_compact_store_word_exec.sv
// Self-checking bench for the compact word-store execute block
`timescale 1ns/1ns
`default_nettype none
module test_compact_store_word_exec
  import csw_pkg::*;
;
  localparam logic [31:0] PA = 32'h0004_2468;
  logic i_clk = 1'b0;
  logic i_rstn, i_instr_valid, i_instr_ext;
  logic i_reversed_byte_order_flag, i_core_high_first_order_flag;
  logic [31:0] i_instr, i_xlat_paddr, o_mem_paddr, m_paddr;
  logic [63:0] i_rf_rdata_a, i_rf_rdata_b, o_rf_wdata, o_xlat_vaddr, o_mem_vaddr, o_mem_data;
  logic i_xlat_done, i_xlat_refill, i_xlat_invalid, i_xlat_modified, i_mem_ack, i_mem_bus_err;
  logic [2:0] i_xlat_cache_attribute, o_mem_cache_attribute, m_cca;
  logic o_ready, o_rf_we, o_xlat_req, o_mem_req, o_exc_valid, o_done;
  logic [4:0] o_rf_raddr_a, o_rf_raddr_b, o_rf_waddr, w_addr;
  csw_exc_t o_exc_code, exc;
  logic [63:0] rf [32];
  logic [63:0] m_vaddr, m_data, w_data;
  logic [3:0] p_wait;
  logic [1:0] p_fault;
  logic p_bus_err, saw_mem, saw_done;
  int n_mismatch = 0;
  int tests_run = 0;
  csw_exec dut_u (.*);
  csw_xlat_mem_model model_u (.i_clk, .i_xlat_req(o_xlat_req), .i_mem_req(o_mem_req),
    .i_wait(p_wait), .i_fault(p_fault), .i_bus_err(p_bus_err), .i_paddr(PA),
    .o_xlat_done(i_xlat_done), .o_xlat_paddr(i_xlat_paddr), .o_cca(i_xlat_cache_attribute),
    .o_refill(i_xlat_refill), .o_invalid(i_xlat_invalid), .o_modified(i_xlat_modified),
    .o_mem_ack(i_mem_ack), .o_mem_bus_err(i_mem_bus_err));
  // Register file reads are combinational; no write-back so read data stays put
  assign i_rf_rdata_a = rf[o_rf_raddr_a];
  assign i_rf_rdata_b = rf[o_rf_raddr_b];
  always #25 i_clk = ~i_clk;
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Offer one instruction, record what the block does until done or exception
  task automatic run_op(input logic [31:0] ins, input logic ext, input logic [1:0] fl,
    input logic [3:0] w, input logic [1:0] f, input logic be);
    int n;
    saw_mem = 1'b0;
    saw_done = 1'b0;
    exc = CSW_EXC_NONE;
    w_addr = 5'h0;
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr <= ins;
    i_instr_ext <= ext;
    {i_core_high_first_order_flag, i_reversed_byte_order_flag} <= fl;
    p_wait <= w;
    p_fault <= f;
    p_bus_err <= be;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    for (n = 0; n < 40 && !saw_done && exc == CSW_EXC_NONE; n++) begin
      @(posedge i_clk);
      if (n == 0) check("busy", o_ready, 1'b0);
      if (o_mem_req && i_mem_ack) begin
        saw_mem = 1'b1;
        m_vaddr = o_mem_vaddr;
        m_paddr = o_mem_paddr;
        m_data = o_mem_data;
        m_cca = o_mem_cache_attribute;
      end
      if (o_rf_we) begin
        w_addr = o_rf_waddr;
        w_data = o_rf_wdata;
      end
      saw_done = saw_done | o_done;
      if (o_exc_valid) exc = o_exc_code;
    end
    if (n == 40) check("completion", 1'b0, 1'b1);
    @(posedge i_clk);
    // Idle again one cycle after the closing pulse, faulted or not
    check("ready", o_ready, 1'b1);
  endtask : run_op
  // Outcome of an instruction: write seen, done pulse, exception code
  task automatic chk_end(input logic m, input logic d, input csw_exc_t c);
    check("mem write", saw_mem, m);
    check("done", saw_done, d);
    check("exception", exc, c);
  endtask : chk_end
  task automatic chk_store(input logic [63:0] ea, input logic [63:0] src);
    chk_end(1'b1, 1'b1, CSW_EXC_NONE);
    check("vaddr", m_vaddr, ea);
    check("paddr", m_paddr, PA ^ {29'h0, i_reversed_byte_order_flag, 2'h0});
    check("data", m_data, src << {ea[2:0] ^ {i_core_high_first_order_flag, 2'h0}, 3'h0});
    check("cca", m_cca, 3'h5);
  endtask : chk_store
  // Short base store, largest offset, every order flag setting
  task automatic t_short_base;
    for (int k = 0; k < 4; k++) begin
      run_op({16'h0, 5'h1b, 3'h2, 3'h3, 5'h1f}, 1'b0, 2'(k), 4'(k), 2'h0, 1'b0);
      chk_store(rf[2] + 64'h7c, rf[3]);
    end
  endtask : t_short_base
  // Extended base store with a negative offset and a slow partner
  task automatic t_ext_base;
    run_op({5'h1e, 6'h3f, 5'h1f, 5'h1b, 3'h4, 3'h5, 5'h18}, 1'b1, 2'h1, 4'h6, 2'h0, 1'b0);
    chk_store(rf[4] - 64'h8, rf[5]);
  endtask : t_ext_base
  // Stack stores: short with mapped register, extended at the sign boundary, bad filler
  task automatic t_stack;
    run_op({16'h0, 5'h1a, 3'h0, 8'hff}, 1'b0, 2'h2, 4'h0, 2'h0, 1'b0);
    chk_store(rf[29] + 64'h3fc, rf[16]);
    run_op({5'h1e, 6'h0, 5'h10, 5'h1a, 3'h7, 3'h0, 5'h0}, 1'b1, 2'h0, 4'h2, 2'h0, 1'b0);
    chk_store(rf[29] - 64'h8000, rf[7]);
    run_op({5'h1e, 6'h0, 5'h10, 5'h1a, 3'h7, 3'h1, 5'h0}, 1'b1, 2'h0, 4'h0, 2'h0, 1'b0);
    chk_end(1'b0, 1'b1, CSW_EXC_NONE);
    // Wrong prefix code on an otherwise clean extended base store
    run_op({5'h1f, 6'h0, 5'h0, 5'h1b, 3'h2, 3'h3, 5'h0}, 1'b1, 2'h0, 4'h0, 2'h0, 1'b0);
    chk_end(1'b0, 1'b1, CSW_EXC_NONE);
  endtask : t_stack
  // Return-address stores; a bus error on them is not reported
  task automatic t_ra;
    run_op({16'h0, 5'h0c, 3'h2, 8'h01}, 1'b0, 2'h3, 4'h1, 2'h0, 1'b1);
    chk_store(rf[29] + 64'h4, rf[31]);
    run_op({5'h1e, 6'h0, 5'h0, 5'h0c, 3'h2, 3'h0, 5'h10}, 1'b1, 2'h0, 4'h0, 2'h0, 1'b0);
    chk_store(rf[29] + 64'h10, rf[31]);
  endtask : t_ra
  // Misaligned address, each translation fault, then a bus error
  task automatic t_faults;
    run_op({5'h1e, 6'h0, 5'h0, 5'h1b, 3'h2, 3'h3, 5'h02}, 1'b1, 2'h0, 4'h0, 2'h0, 1'b0);
    chk_end(1'b0, 1'b0, CSW_EXC_ADDR);
    for (int f = 1; f < 4; f++) begin
      run_op({16'h0, 5'h1b, 3'h2, 3'h3, 5'h01}, 1'b0, 2'h0, 4'h3, 2'(f), 1'b0);
      chk_end(1'b0, 1'b0, csw_exc_t'(f + 1));
    end
    run_op({16'h0, 5'h1a, 3'h3, 8'h02}, 1'b0, 2'h0, 4'h2, 2'h0, 1'b1);
    chk_end(1'b1, 1'b0, CSW_EXC_BUS);
  endtask : t_faults
  // Register exclusive-or into the first register
  task automatic t_xor;
    run_op({16'h0, 5'h1d, 3'h1, 3'h2, 5'h0e}, 1'b0, 2'h0, 4'h0, 2'h0, 1'b0);
    chk_end(1'b0, 1'b1, CSW_EXC_NONE);
    check("xor addr", w_addr, 5'h11);
    check("xor data", w_data, rf[17] ^ rf[2]);
    // The exclusive-or has no extended form, so no write-back
    run_op({5'h1e, 11'h0, 5'h1d, 3'h1, 3'h2, 5'h0e}, 1'b1, 2'h0, 4'h0, 2'h0, 1'b0);
    chk_end(1'b0, 1'b1, CSW_EXC_NONE);
    check("ext xor addr", w_addr, 5'h00);
  endtask : t_xor
  // Reset, then the scenarios in turn
  initial begin
    for (int i = 0; i < 32; i++) rf[i] = {32'h0123_4567, 16'(i), 16'h0};
    i_rstn = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = 32'h0;
    i_instr_ext = 1'b0;
    {i_core_high_first_order_flag, i_reversed_byte_order_flag} = 2'h0;
    p_wait = 4'h0;
    p_fault = 2'h0;
    p_bus_err = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_short_base();
    t_ext_base();
    t_stack();
    t_ra();
    t_faults();
    t_xor();
    end_of_test();
  end
  // Hang guard, far beyond the few hundred cycles the scenarios need
  initial begin
    #(50 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule : test_compact_store_word_exec
`default_nettype wire
